// [bench/iopwm_pads_model.sv]
// Model of the circuitry attached to the port pins.
`timescale 1ns/1ps
module iopwm_pads_model (
  input  wire logic                   clock,
  input  wire iopwm_pkg::iopwm_pins_t pad_out,
  input  wire iopwm_pkg::iopwm_pins_t pad_oe,
  input  wire iopwm_pkg::iopwm_pins_t pad_pu,
  input  wire iopwm_pkg::iopwm_pins_t ext_drv,
  input  wire iopwm_pkg::iopwm_pins_t ext_en,
  output iopwm_pkg::iopwm_pins_t      pad_in
);
  logic [23:0] flt_q = 24'h000000;
  // An undriven line without pull-up wanders, so it toggles every cycle.
  always @(posedge clock) flt_q <= ~flt_q;
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_drv)
                | (~pad_oe & ~ext_en & (pad_pu | flt_q));
endmodule : iopwm_pads_model

// [bench/tb.sv]
// Self-checking bench for the I/O port and pulse-width block.
`timescale 1ns/1ps
module tb;
  logic                   clock = 1'b0;
  logic                   arst_n = 1'b0;
  iopwm_pkg::iopwm_bus_t  bus_req = '0;
  logic [7:0]             bus_rdata;
  iopwm_pkg::iopwm_pins_t pad_in, pad_out, pad_oe, pad_pu;
  iopwm_pkg::iopwm_pins_t ext_drv = '0;
  iopwm_pkg::iopwm_pins_t ext_en = '0;
  logic                   tmr0_ovf = 1'b0;
  logic                   tmr1_ovf = 1'b0;
  logic                   buzz_src = 1'b0;
  logic                   halted = 1'b0;
  logic                   wake;
  logic [7:0]             prescale_out;
  int                     n_errors = 0;
  int                     checks_done = 0;
  int                     c;
  int                     c71;
  iopwm_pkg::iopwm_pins_t pad_out71;
  logic                   p;

  always #2 clock = ~clock;

  iopwm_top i_dut (.clock(clock), .arst_n(arst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pu(pad_pu),
    .tmr0_ovf(tmr0_ovf), .tmr1_ovf(tmr1_ovf), .buzz_src(buzz_src), .halted(halted),
    .wake(wake), .prescale_out(prescale_out));
  iopwm_top #(.PWM_MODE71(1'b1)) i_dut71 (.clock(clock), .arst_n(arst_n), .bus_req(bus_req),
    .bus_rdata(), .pad_in(pad_in), .pad_out(pad_out71), .pad_oe(), .pad_pu(),
    .tmr0_ovf(tmr0_ovf), .tmr1_ovf(tmr1_ovf), .buzz_src(buzz_src), .halted(halted),
    .wake(), .prescale_out());
  iopwm_pads_model i_pads (.clock(clock), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pu(pad_pu), .ext_drv(ext_drv), .ext_en(ext_en), .pad_in(pad_in));

  task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic give_verdict;
    $display("Checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  task automatic bus(input logic [2:0] s, input iopwm_pkg::iopwm_bitop_t k,
                     input logic [2:0] b, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req <= '{rd: s[2], wr: s[1], bop: s[0], kind: k, bit_idx: b, addr: a, wdata: d};
    @(posedge clock);
    bus_req <= '0;
    #1;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(3'b010, iopwm_pkg::IOPWM_OP_SET, 3'h0, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    bus(3'b100, iopwm_pkg::IOPWM_OP_SET, 3'h0, a, 8'h00);
  endtask : rd

  task automatic bop(input iopwm_pkg::iopwm_bitop_t k, input logic [2:0] b);
    bus(3'b001, k, b, 8'h14, 8'h00);
  endtask : bop

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc

  // Counts the cycles in which bit idx of {wake, pad_out} is high.
  task automatic count_hi(input int idx, input int n);
    c = 0;
    c71 = 0;
    repeat (n) begin
      cyc(1);
      c += int'(({wake, pad_out} >> idx) & 25'h1);
      c71 += int'((pad_out71 >> idx) & 24'h1);
    end
  endtask : count_hi

  task automatic wait_pre(input logic [7:0] v);
    for (int i = 0; i < 600 && prescale_out !== v; i++) cyc(1);
    if (prescale_out !== v) begin
      n_errors++;
      give_verdict();
    end
  endtask : wait_pre

  task automatic t_reset;
    check("oe", pad_oe, 24'h000000);
    check("pu", pad_pu, 24'hffffff);
    for (int i = 0; i < iopwm_pkg::NUM_PORTS; i++) begin
      rd(iopwm_pkg::DIR_ADDR[i]);
      check("dir", bus_rdata, 24'hff);
    end
    rd(8'h16);
    check("unmapped", bus_rdata, 24'h00);
    rd(8'h14);
    check("in_b", bus_rdata, 24'hff);
  endtask : t_reset

  task automatic t_ports;
    wr(8'h15, 8'h00);
    wr(8'h14, 8'h5a);
    cyc(3);
    check("oe_b", pad_oe.port_b, 24'hff);
    check("out_b", pad_out.port_b, 24'h5a);
    rd(8'h14);
    check("rd_out", bus_rdata, 24'h5a);
    wr(8'h15, 8'hf0);
    @(posedge clock);
    ext_en.port_b <= 8'hff;
    ext_drv.port_b <= 8'ha5;
    cyc(6);
    check("oe_b2", pad_oe.port_b, 24'h0f);
    rd(8'h14);
    check("rd_mix", bus_rdata, 24'haa);
    @(posedge clock);
    ext_drv.port_b <= 8'h3c;
    cyc(6);
    rd(8'h14);
    check("rd_live", bus_rdata, 24'h3a);
  endtask : t_ports

  task automatic t_bitops;
    bop(iopwm_pkg::IOPWM_OP_SET, 3'h0);
    bop(iopwm_pkg::IOPWM_OP_CLR, 3'h4);
    wr(8'h15, 8'h00);
    rd(8'h14);
    check("setclr", bus_rdata, 24'h2b);
    bop(iopwm_pkg::IOPWM_OP_CPL, 3'h0);
    rd(8'h14);
    check("cpl", bus_rdata, 24'hd4);
    bop(iopwm_pkg::IOPWM_OP_CPLA, 3'h0);
    check("cpla", bus_rdata, 24'h2b);
    rd(8'h14);
    check("cpla_keep", bus_rdata, 24'hd4);
    bop(iopwm_pkg::IOPWM_OP_SET, 3'h0);
    rd(8'h14);
    check("set_out", bus_rdata, 24'hd5);
    wr(8'h15, 8'hff);
    cyc(3);
    check("oe_b3", pad_oe.port_b, 24'h00);
  endtask : t_bitops

  task automatic t_pulse;
    logic [7:0] duty [3] = '{8'h00, 8'h65, 8'hff};
    wr(8'h19, 8'h00);
    wr(8'h18, 8'h0f);
    foreach (duty[k]) begin
      for (int ch = 0; ch < 4; ch += 3) begin
        wr(iopwm_pkg::DUTY_ADDR[ch], duty[k]);
        wait_pre(8'h80);
        wait_pre(8'h00);
        count_hi(16 + ch, 256);
        check("duty", 24'(c), 24'(duty[k]));
        check("duty71", 24'(c71), 24'(duty[k]));
      end
    end
    wr(8'h18, 8'h00);
    cyc(3);
    count_hi(19, 256);
    check("pwm_off", 24'(c), 24'h0);
    check("pwm_off71", 24'(c71), 24'h0);
  endtask : t_pulse

  task automatic t_shared;
    wr(8'h13, 8'hf4);
    wr(8'h12, 8'h09);
    @(posedge clock);
    buzz_src <= 1'b1;
    cyc(3);
    check("buzz1", pad_out.port_a[1:0], 24'h1);
    @(posedge clock);
    buzz_src <= 1'b0;
    cyc(3);
    check("buzz0", pad_out.port_a[1:0], 24'h2);
    p = pad_out.port_a[3];
    @(posedge clock);
    tmr0_ovf <= 1'b1;
    @(posedge clock);
    tmr0_ovf <= 1'b0;
    cyc(3);
    check("div_tog", pad_out.port_a[3], {23'h000000, ~p});
    @(posedge clock);
    tmr1_ovf <= 1'b1;
    @(posedge clock);
    tmr1_ovf <= 1'b0;
    cyc(3);
    check("div_sel", pad_out.port_a[3], {23'h000000, ~p});
    wr(8'h12, 8'h01);
    cyc(3);
    check("div_off", pad_out.port_a[3], 24'h0);
  endtask : t_shared

  task automatic t_wake;
    @(posedge clock);
    halted <= 1'b1;
    ext_en.port_a <= 8'h80;
    cyc(10);
    @(posedge clock);
    ext_drv.port_a <= 8'h80;
    count_hi(24, 12);
    check("wake", 24'(c), 24'h1);
    @(posedge clock);
    halted <= 1'b0;
  endtask : t_wake

  initial begin
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    cyc(4);
    t_reset();
    t_ports();
    t_bitops();
    t_pulse();
    t_shared();
    t_wake();
    give_verdict();
  end
endmodule : tb

// [verilog/iopwm_pkg.sv]
// Constants and carrier types for the I/O port and pulse-width block.
package iopwm_pkg;

  // Data-memory addresses of the port latches, index 0 = port A, 1 = port B, 2 = port D.
  localparam logic [2:0][7:0] DATA_ADDR = {8'h18, 8'h14, 8'h12};
  localparam logic [2:0][7:0] DIR_ADDR  = {8'h19, 8'h15, 8'h13};
  // Duty registers of the four pulse channels, index = channel.
  localparam logic [3:0][7:0] DUTY_ADDR = {8'h1d, 8'h1c, 8'h1b, 8'h1a};

  localparam int NUM_PORTS = 3;
  localparam int NUM_CHAN  = 4;

  // Value after reset.
  localparam logic [7:0] DIR_RESET   = 8'hff;
  localparam logic [7:0] DATA_RESET  = 8'h00;
  localparam logic [7:0] DUTY_RESET  = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // Field positions of the shared pins.
  localparam int FDIV_BIT  = 3;
  localparam int BUZZ_BIT  = 0;
  localparam int BUZZN_BIT = 1;

  // Prescaler values at which one full pulse period ends and starts.
  localparam logic [7:0] CNT_LAST  = 8'hff;
  localparam logic [7:0] CNT_FIRST = 8'h00;
  localparam logic [7:0] CNT_STEP  = 8'h01;

  typedef enum logic [1:0] {
    IOPWM_OP_SET,
    IOPWM_OP_CLR,
    IOPWM_OP_CPL,
    IOPWM_OP_CPLA
  } iopwm_bitop_t;

  typedef struct packed {
    logic         rd;
    logic         wr;
    logic         bop;
    iopwm_bitop_t kind;
    logic [2:0]   bit_idx;
    logic [7:0]   addr;
    logic [7:0]   wdata;
  } iopwm_bus_t;

  typedef struct packed {
    logic [7:0] port_d;
    logic [7:0] port_b;
    logic [7:0] port_a;
  } iopwm_pins_t;

endpackage : iopwm_pkg

// [verilog/iopwm_top.sv]
// Three bidirectional 8-bit ports with divider, buzzer and pulse-width alternate outputs.
//
// Overview of operation
// - Port reads return the pad level after three sampling stages and a filter, not the level at read time.
// - Output latches hold their value until software writes them again.
// - One direction bit per line: 1 is input, 0 is push-pull output.
// - Port read returns pad level for input bits, latch contents for output bits.
// - After reset all lines are inputs, pulled high where the pull-up is fitted.
// - Bit set, bit clear and whole-port complement read the port, modify, write latch or accumulator.
// - Any port A input line can wake the device from halt when its filtered level changes.
// - Each port has a build-time pull-up option; without it inputs float.
// - Divider option drives port A bit 3 with the overflow divider when an output.
// - Port A bit 3 latch gates the divider: 1 passes it, 0 forces low.
// - Divider toggles on each overflow of the selected timer.
// - Buzzer option puts buzzer on port A bit 0 and, when bits 0 and 1 are both outputs, its complement on bit 1.
// - Pulse option drives port D bits 0 to 3 outputs, gated by their latches.
// - Four pulse channels, each with its own 8-bit duty register, from system clock.
// - A build-time option selects the 6+2 or 7+1 modulation split.
// - In 6+2, a period is four modulation cycles of 64 clocks.
// - In 6+2, cycle i is high base+1 clocks when i below extra count.
// - In 7+1, a period is two modulation cycles of 128 clocks.
// - In 7+1, cycle i is high base+1 clocks when i below extra bit.
// - High time over a 256-clock period equals the duty register value.
// - Pulse channels count from the shared prescaler chain, not their own counter.
`timescale 1ns/1ps

module iopwm_top #(
  parameter bit       FDIV_EN     = 1'b1,
  parameter bit       FDIV_SEL_T1 = 1'b0,
  parameter bit       BUZZ_EN     = 1'b1,
  parameter bit       PWM_EN      = 1'b1,
  parameter bit       PWM_MODE71  = 1'b0,
  parameter bit [2:0] PULLUP_EN   = 3'b111
) (
  input  wire logic                   clock,
  input  wire logic                   arst_n,
  input  wire iopwm_pkg::iopwm_bus_t  bus_req,
  output logic [7:0]                  bus_rdata,
  input  wire iopwm_pkg::iopwm_pins_t pad_in,
  output iopwm_pkg::iopwm_pins_t      pad_out,
  output iopwm_pkg::iopwm_pins_t      pad_oe,
  output iopwm_pkg::iopwm_pins_t      pad_pu,
  input  wire logic                   tmr0_ovf,
  input  wire logic                   tmr1_ovf,
  input  wire logic                   buzz_src,
  input  wire logic                   halted,
  output logic                        wake,
  output logic [7:0]                  prescale_out
);

  logic rst_s1_q;
  logic rst_n_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // Port state, index 0 = port A, 1 = port B, 2 = port D.
  logic [2:0][7:0] dat_q, dat_d;
  logic [2:0][7:0] dir_q, dir_d;
  logic [3:0][7:0] duty_q, duty_d;
  logic [3:0][7:0] act_q, act_d;
  logic [7:0]      cnt_q, cnt_d;
  logic            fdiv_q, fdiv_d;
  logic [7:0]      rdata_q, rdata_d;
  logic [2:0][7:0] pad_vec;
  logic [2:0][7:0] s1_q, s2_q, s3_q;
  logic [2:0][7:0] filt_q, filt_d;
  logic [2:0][7:0] out_q, out_d;
  logic [2:0][7:0] oe_q, oe_d;
  logic [2:0][7:0] pu_q, pu_d;
  logic            wake_q, wake_d;
  logic [3:0]      pwm_hi;
  logic            src_ovf;

  assign pad_vec = pad_in;

  function automatic logic [7:0] port_view(input logic [7:0] dir, input logic [7:0] lat,
                                           input logic [7:0] pad);
    port_view = (dir & pad) | (~dir & lat);
  endfunction : port_view

  function automatic logic [7:0] bit_op(input logic [7:0] v, input iopwm_pkg::iopwm_bitop_t k,
                                        input logic [2:0] idx);
    logic [7:0] r;
    r = v;
    unique case (k)
      iopwm_pkg::IOPWM_OP_SET:  r[idx] = 1'b1;
      iopwm_pkg::IOPWM_OP_CLR:  r[idx] = 1'b0;
      iopwm_pkg::IOPWM_OP_CPL:  r = ~v;
      iopwm_pkg::IOPWM_OP_CPLA: r = ~v;
    endcase
    bit_op = r;
  endfunction : bit_op

  // Level of one channel at a prescaler count; high from the cycle start.
  function automatic logic pwm_level(input logic [7:0] cnt, input logic [7:0] duty);
    logic [8:0] len;
    logic [8:0] pos;
    len = 9'h000;
    pos = 9'h000;
    if (PWM_MODE71) begin
      len = {2'b00, duty[7:1]} + {8'h00, (cnt[7] < duty[0])};
      pos = {2'b00, cnt[6:0]};
    end else begin
      len = {3'b000, duty[7:2]} + {8'h00, (cnt[7:6] < duty[1:0])};
      pos = {3'b000, cnt[5:0]};
    end
    pwm_level = pos < len;
  endfunction : pwm_level

  // Register file on the data-memory bus.
  always_comb begin
    logic [7:0] pv;
    logic [7:0] rv;
    pv      = 8'h00;
    rv      = 8'h00;
    dat_d   = dat_q;
    dir_d   = dir_q;
    duty_d  = duty_q;
    rdata_d = iopwm_pkg::RDATA_RESET;
    for (int i = 0; i < iopwm_pkg::NUM_PORTS; i++) begin
      pv = port_view(dir_q[i], dat_q[i], filt_q[i]);
      if (bus_req.addr == iopwm_pkg::DATA_ADDR[i]) begin
        if (bus_req.rd) begin
          rdata_d = pv;
        end
        if (bus_req.wr) begin
          dat_d[i] = bus_req.wdata;
        end else if (bus_req.bop) begin
          rv = bit_op(pv, bus_req.kind, bus_req.bit_idx);
          if (bus_req.kind == iopwm_pkg::IOPWM_OP_CPLA) begin
            rdata_d = rv;
          end else begin
            dat_d[i] = rv;
          end
        end
      end
      if (bus_req.addr == iopwm_pkg::DIR_ADDR[i]) begin
        if (bus_req.rd) begin
          rdata_d = dir_q[i];
        end
        if (bus_req.wr) begin
          dir_d[i] = bus_req.wdata;
        end
      end
    end
    for (int j = 0; j < iopwm_pkg::NUM_CHAN; j++) begin
      if (bus_req.addr == iopwm_pkg::DUTY_ADDR[j]) begin
        if (bus_req.rd) begin
          rdata_d = duty_q[j];
        end
        if (bus_req.wr) begin
          duty_d[j] = bus_req.wdata;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      dat_q   <= {3{iopwm_pkg::DATA_RESET}};
      dir_q   <= {3{iopwm_pkg::DIR_RESET}};
      duty_q  <= {4{iopwm_pkg::DUTY_RESET}};
      rdata_q <= iopwm_pkg::RDATA_RESET;
    end else begin
      dat_q   <= dat_d;
      dir_q   <= dir_d;
      duty_q  <= duty_d;
      rdata_q <= rdata_d;
    end
  end

  // Pad sampling: a level counts once the second and third stages agree.
  always_comb begin
    filt_d = ((s2_q ^ s3_q) & filt_q) | (~(s2_q ^ s3_q) & s3_q);
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      filt_q <= '0;
    end else begin
      s1_q   <= pad_vec;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= filt_d;
    end
  end

  // Prescaler chain shared with the timers; the pulse channels read it directly.
  always_comb begin
    cnt_d = cnt_q + iopwm_pkg::CNT_STEP;
    act_d = act_q;
    if (cnt_q == iopwm_pkg::CNT_LAST) begin
      act_d = duty_q;
    end
    for (int j = 0; j < iopwm_pkg::NUM_CHAN; j++) begin
      pwm_hi[j] = pwm_level(cnt_q, act_q[j]);
    end
    src_ovf = FDIV_SEL_T1 ? tmr1_ovf : tmr0_ovf;
    fdiv_d  = src_ovf ? ~fdiv_q : fdiv_q;
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cnt_q  <= iopwm_pkg::CNT_FIRST;
      act_q  <= {4{iopwm_pkg::DUTY_RESET}};
      fdiv_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      act_q  <= act_d;
      fdiv_q <= fdiv_d;
    end
  end

  // Pad drive with alternate functions.
  always_comb begin
    out_d = dat_q;
    oe_d  = ~dir_q;
    for (int i = 0; i < iopwm_pkg::NUM_PORTS; i++) begin
      pu_d[i] = PULLUP_EN[i] ? dir_q[i] : 8'h00;
    end
    if (FDIV_EN) begin
      out_d[0][iopwm_pkg::FDIV_BIT] = dat_q[0][iopwm_pkg::FDIV_BIT] & fdiv_q;
    end
    if (BUZZ_EN) begin
      out_d[0][iopwm_pkg::BUZZ_BIT] = dat_q[0][iopwm_pkg::BUZZ_BIT] & buzz_src;
      if (!dir_q[0][iopwm_pkg::BUZZ_BIT] && !dir_q[0][iopwm_pkg::BUZZN_BIT]) begin
        out_d[0][iopwm_pkg::BUZZN_BIT] = dat_q[0][iopwm_pkg::BUZZ_BIT] & ~buzz_src;
      end
    end
    if (PWM_EN) begin
      for (int j = 0; j < iopwm_pkg::NUM_CHAN; j++) begin
        out_d[2][j] = dat_q[2][j] & pwm_hi[j];
      end
    end
    wake_d = halted && ((filt_d[0] ^ filt_q[0]) & dir_q[0]) != 8'h00;
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      out_q  <= '0;
      oe_q   <= '0;
      pu_q   <= '0;
      wake_q <= 1'b0;
    end else begin
      out_q  <= out_d;
      oe_q   <= oe_d;
      pu_q   <= pu_d;
      wake_q <= wake_d;
    end
  end

  assign bus_rdata    = rdata_q;
  assign pad_out      = out_q;
  assign pad_oe       = oe_q;
  assign pad_pu       = pu_q;
  assign wake         = wake_q;
  assign prescale_out = cnt_q;

  // Helper: high clocks of channel 0 accumulated over one period.
  logic [8:0] hi_sum_q;

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      hi_sum_q <= 9'h000;
    end else if (cnt_q == iopwm_pkg::CNT_FIRST) begin
      hi_sum_q <= {8'h00, pwm_hi[0]};
    end else begin
      hi_sum_q <= hi_sum_q + {8'h00, pwm_hi[0]};
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n_q);

  sequence s_read_b;
    bus_req.rd && bus_req.addr == iopwm_pkg::DATA_ADDR[1];
  endsequence

  sequence s_div_tick;
    src_ovf;
  endsequence

  a_read_input_pad: assert property (
    s_read_b and (dir_q[1] == 8'hff) |=> bus_rdata == $past(filt_q[1]))
    else $error("input read did not return the pad level");

  a_read_output_latch: assert property (
    s_read_b and (dir_q[1] == 8'h00) |=> bus_rdata == $past(dat_q[1]))
    else $error("output read did not return the latch");

  a_latch_holds: assert property (
    !((bus_req.wr || bus_req.bop) && bus_req.addr == iopwm_pkg::DATA_ADDR[1])
    |=> dat_q[1] == $past(dat_q[1]))
    else $error("port latch changed without a write");

  a_dir_input_oe: assert property (
    bus_req.wr && bus_req.addr == iopwm_pkg::DIR_ADDR[1] && bus_req.wdata == 8'hff
    |=> ##1 pad_oe.port_b == 8'h00)
    else $error("input direction still drives the pad");

  a_bitop_set: assert property (
    bus_req.bop && !bus_req.wr && bus_req.kind == iopwm_pkg::IOPWM_OP_SET
    && bus_req.addr == iopwm_pkg::DATA_ADDR[1] && dir_q[1] == 8'h00
    |=> dat_q[1][$past(bus_req.bit_idx)] == 1'b1)
    else $error("bit set did not reach the latch");

  a_div_gate_low: assert property (
    FDIV_EN && !dat_q[0][iopwm_pkg::FDIV_BIT] |=> !pad_out.port_a[iopwm_pkg::FDIV_BIT])
    else $error("divider line not forced low");

  a_div_pass: assert property (
    FDIV_EN && dat_q[0][iopwm_pkg::FDIV_BIT]
    |=> pad_out.port_a[iopwm_pkg::FDIV_BIT] == $past(fdiv_q))
    else $error("divider line does not follow the divider");

  a_div_toggles: assert property (
    s_div_tick |=> fdiv_q != $past(fdiv_q))
    else $error("divider did not toggle on overflow");

  a_buzz_gate_low: assert property (
    BUZZ_EN && !dat_q[0][iopwm_pkg::BUZZ_BIT] |=> !pad_out.port_a[iopwm_pkg::BUZZ_BIT])
    else $error("buzzer line not forced low");

  a_buzz_pair_inverse: assert property (
    BUZZ_EN && dat_q[0][iopwm_pkg::BUZZ_BIT]
    && !dir_q[0][iopwm_pkg::BUZZ_BIT] && !dir_q[0][iopwm_pkg::BUZZN_BIT]
    |=> pad_out.port_a[iopwm_pkg::BUZZN_BIT] != pad_out.port_a[iopwm_pkg::BUZZ_BIT])
    else $error("buzzer lines are not complementary");

  a_pwm_force_low: assert property (
    PWM_EN && !dat_q[2][0] |=> !pad_out.port_d[0])
    else $error("pulse line not forced low");

  a_pwm_period_sum: assert property (
    cnt_q == iopwm_pkg::CNT_LAST |-> hi_sum_q + {8'h00, pwm_hi[0]} == {1'b0, act_q[0]})
    else $error("period high time differs from duty");

  a_duty_deferred: assert property (
    cnt_q != iopwm_pkg::CNT_LAST |=> act_q[0] == $past(act_q[0]))
    else $error("duty changed inside a period");

  a_oe_follows_dir: assert property (
    1'b1 |=> pad_oe == ~$past(dir_q))
    else $error("output enable does not follow the direction bits");

  a_pullup_inputs: assert property (
    1'b1 |=> pad_pu.port_a == (PULLUP_EN[0] ? $past(dir_q[0]) : 8'h00))
    else $error("pull-up enable does not follow the input lines");

  a_wake_needs_halt: assert property (
    !halted |=> !wake)
    else $error("wake pulse outside halt");

  a_prescale_step: assert property (
    1'b1 |=> prescale_out == $past(cnt_q) + iopwm_pkg::CNT_STEP)
    else $error("prescaler did not advance by one");

  a_rdata_idle: assert property (
    !bus_req.rd && !bus_req.bop |=> bus_rdata == iopwm_pkg::RDATA_RESET)
    else $error("read data not cleared without a read");

endmodule : iopwm_top
